// ### hw/scap_policy.v
// Functional notes
// RULE1 - Power-delivery messages travel only as bi-phase mark coding on config wire.
// RULE2 - No power-delivery messaging after attach until supply rail is stable.
// RULE3 - Without contract advertise by rating: 3 A, 1.5 A or default, within deadline.
// RULE4 - Shared-capacity 3 A source may start at 1.5 A then raise it.
// RULE5 - During suspend a power-delivery source may advertise default level.
// RULE6 - Revision-two contract: 1.5 A or 3.0 A, after first ready acknowledge.
// RULE7 - Revision-three contract: follow collision-avoidance advertisement from contract entry; code samples ca_adv_in only on event_any cycles.
// RULE8 - Adapter reports worst-case ground and supply impedance in identity response.
// RULE9 - Host assumes 5 A cable only if source offered above 3 A.
// RULE10 - Ground limit = 0.25 V / (0.25 V / cable + ground impedance), 1 mohm units.
// RULE11 - Supply limit uses 0.75 V and both impedances; supply in 2 mohm units.
// RULE12 - Host draw capped below advertisement when impedance limits are lower.
// RULE13 - Above 3.0 A source must run cable identity discovery first.
// RULE14 - Higher voltage or role-swap sources negotiate only by power-delivery messaging.
// RULE15 - Sink ignores advertisement changes during an active contract.
// RULE16 - Two-bit advertisement code, updated only on contract, suspend or attach events; code also updates on raise_in and ps_rdy_ack_in pulses.
//
// Purpose: Chooses the pull-up current advertisement and host current limits
// Assumes: Protocol engine, rail monitor and cable discovery are outside on the same clock
// Notes: Attach, suspend and rail-good come from pins and are synchronised
`default_nettype none
`include "scap_defs.vh"
module scap_policy #(
    parameter [15:0] RATING_MA = 16'h0bb8,
    parameter SHARED_CAP = 0,
    parameter PD_REV3 = 0,
    parameter SUSPEND_DEFAULT = 1,
    parameter HIGH_VOLT_OR_SWAP = 0,
    parameter VBUSON_CYC = `SCAP_VBUSON_CYC,
    parameter STABLE_CYC = `SCAP_STABLE_CYC
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire attach_in,
    input wire suspend_in,
    input wire rail_good_in,
    input wire contract_in,
    input wire ps_rdy_ack_in,
    input wire raise_in,
    input wire [1:0] ca_adv_in,
    input wire [15:0] src_max_pdo_ma_in,
    input wire adapter_present_in,
    input wire [15:0] adapter_ground_resistance_in,
    input wire [15:0] adapter_supply_resistance_in,
    input wire lower_detach_in,
    input wire cable_disc_done_in,
    input wire [15:0] cable_cap_ma_in,
    output reg [1:0] current_advert_pullup_out,
    output reg advert_valid_out,
    output reg pd_msg_enable_out,
    output reg pd_only_out,
    output reg offer_above_3a_out,
    output reg [15:0] host_limit_ma_out,
    output reg limit_valid_out
);
    localparam ST_IDLE = 4'h1;
    localparam ST_GND = 4'h2;
    localparam ST_SUP = 4'h4;
    localparam ST_DONE = 4'h8;

    wire [2:0] pins_s;
    wire att_s = pins_s[0];
    wire susp_s = pins_s[1];
    wire rail_s = pins_s[2];

    scap_sync #(.W(3)) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in({rail_good_in, suspend_in, attach_in}),
        .sync_out(pins_s)
    );

    function [1:0] rate_level;
        input [15:0] ma;
        begin
            if (ma >= `SCAP_RATE_3A0_MA)
                rate_level = `SCAP_ADV_3A0;
            else if (ma >= `SCAP_RATE_1A5_MA)
                rate_level = `SCAP_ADV_1A5;
            else
                rate_level = `SCAP_ADV_DEFAULT;
        end
    endfunction

    function [15:0] adv_ma;
        input [1:0] lvl;
        begin
            case (lvl)
                `SCAP_ADV_3A0: adv_ma = `SCAP_RATE_3A0_MA;
                `SCAP_ADV_1A5: adv_ma = `SCAP_RATE_1A5_MA;
                default: adv_ma = 16'h01f4;
            endcase
        end
    endfunction

    reg att_q, susp_q, contract_q, raised_q, rev2_ok_q;
    reg [31:0] stable_cnt_q;
    reg [31:0] on_cnt_q;
    reg [1:0] adv_d;

    wire attach_rise = att_s && !att_q;
    wire event_any = (att_s != att_q) || (susp_s != susp_q) || (contract_in != contract_q)
                   || ps_rdy_ack_in || raise_in;

    // Revision-two only switches once the first ready is acknowledged
    wire [1:0] rated = rate_level(RATING_MA);
    always @* begin
        if (!att_s)
            adv_d = `SCAP_ADV_DEFAULT;
        else if (susp_s && (SUSPEND_DEFAULT != 0))
            adv_d = `SCAP_ADV_DEFAULT; // [RULE5]
        else if (contract_in && (PD_REV3 != 0))
            adv_d = ca_adv_in; // [RULE7]
        else if (contract_in && (rev2_ok_q || ps_rdy_ack_in))
            adv_d = (rated == `SCAP_ADV_3A0) ? `SCAP_ADV_3A0 : `SCAP_ADV_1A5; // [RULE6]
        else if (contract_in)
            adv_d = current_advert_pullup_out;
        else if ((SHARED_CAP != 0) && rated == `SCAP_ADV_3A0 && !(raised_q || raise_in))
            adv_d = `SCAP_ADV_1A5; // [RULE4]
        else
            adv_d = rated; // [RULE3]
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            att_q <= 1'b0;
            susp_q <= 1'b0;
            contract_q <= 1'b0;
            raised_q <= 1'b0;
            rev2_ok_q <= 1'b0;
            stable_cnt_q <= 32'h0;
            on_cnt_q <= 32'h0;
            current_advert_pullup_out <= `SCAP_ADV_DEFAULT;
            advert_valid_out <= 1'b0;
            pd_msg_enable_out <= 1'b0;
            pd_only_out <= 1'b0;
        end else begin
            att_q <= att_s;
            susp_q <= susp_s;
            contract_q <= contract_in;
            pd_only_out <= (HIGH_VOLT_OR_SWAP != 0); // [RULE14]
            if (!att_s || !contract_in)
                rev2_ok_q <= 1'b0;
            else if (ps_rdy_ack_in)
                rev2_ok_q <= 1'b1;
            if (!att_s)
                raised_q <= 1'b0;
            else if (raise_in)
                raised_q <= 1'b1;
            // Only events move the advertisement, so it never drifts mid-contract
            if (event_any)
                current_advert_pullup_out <= adv_d; // [RULE16]
            // Advertisement lands one cycle after attach, well inside the deadline
            if (!att_s)
                on_cnt_q <= 32'h0;
            else if (on_cnt_q < VBUSON_CYC)
                on_cnt_q <= on_cnt_q + 32'h1;
            advert_valid_out <= att_s && (att_q || on_cnt_q >= VBUSON_CYC); // [RULE3]
            // Messaging waits for a rail that stayed good for the whole window
            if (!att_s || !rail_s || attach_rise)
                stable_cnt_q <= 32'h0;
            else if (stable_cnt_q < STABLE_CYC)
                stable_cnt_q <= stable_cnt_q + 32'h1;
            pd_msg_enable_out <= att_s && rail_s && (stable_cnt_q >= STABLE_CYC); // [RULE2] [RULE1]
        end
    end

    // Offers above 3 A wait for cable capacity from identity discovery
    always @(posedge sys_clk_in) begin
        if (rst_in)
            offer_above_3a_out <= 1'b0;
        else
            offer_above_3a_out <= (RATING_MA > `SCAP_RATE_3A0_MA) && cable_disc_done_in
                                && (cable_cap_ma_in > `SCAP_RATE_3A0_MA); // [RULE13]
    end

    // Host-side limit: ground then supply division through one shared divider, supply skipped on lower detach
    reg [3:0] st_q;
    reg [31:0] gnd_lim_q;
    reg div_start_q;
    reg [31:0] num_q, den_q;
    wire [31:0] quo;
    wire div_done;
    wire [15:0] cable_ma = (src_max_pdo_ma_in > `SCAP_RATE_3A0_MA) ?
                           `SCAP_CABLE_5A_MA : `SCAP_RATE_3A0_MA; // [RULE9]
    // Cable term in microohm (mV*1e6/mA) so it adds to the adapter terms
    wire [31:0] cab_gnd_uohm = (`SCAP_GND_MV * 32'd1000000) / {16'h0, cable_ma};
    wire [31:0] cab_sup_uohm = (`SCAP_SUP_MV * 32'd1000000) / {16'h0, cable_ma};
    wire [31:0] gnd_uohm = {16'h0, adapter_ground_resistance_in} * 32'd1000;
    wire [31:0] sup_uohm = {16'h0, adapter_supply_resistance_in} * 32'd1000
                         * `SCAP_SUP_STEP_MOHM;
    wire [31:0] adv_lim = {16'h0, adv_ma(current_advert_pullup_out)};

    scap_div #(.W(32)) u_div (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .start_in(div_start_q),
        .num_in(num_q),
        .den_in(den_q),
        .quo_out(quo),
        .done_out(div_done)
    );

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_q <= ST_IDLE;
            gnd_lim_q <= 32'h0;
            div_start_q <= 1'b0;
            num_q <= 32'h0;
            den_q <= 32'h0;
            host_limit_ma_out <= 16'h0;
            limit_valid_out <= 1'b0;
        end else begin
            div_start_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    limit_valid_out <= 1'b0;
                    if (adapter_present_in) begin
                        num_q <= `SCAP_GND_MV * 32'd1000000; // mV*1e6 / uohm = mA
                        den_q <= cab_gnd_uohm + gnd_uohm; // [RULE10]
                        div_start_q <= 1'b1;
                        st_q <= ST_GND;
                    end else begin
                        host_limit_ma_out <= adv_lim[15:0];
                        limit_valid_out <= 1'b1;
                    end
                end
                ST_GND: begin
                    if (div_done) begin
                        gnd_lim_q <= quo;
                        num_q <= `SCAP_SUP_MV * 32'd1000000;
                        den_q <= cab_sup_uohm + sup_uohm + gnd_uohm; // [RULE11]
                        div_start_q <= !lower_detach_in;
                        st_q <= lower_detach_in ? ST_DONE : ST_SUP;
                    end
                end
                ST_SUP: begin
                    if (div_done) begin
                        if (quo < gnd_lim_q)
                            gnd_lim_q <= quo; // [RULE11]
                        st_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Take the smallest of advertisement and impedance limits
                    host_limit_ma_out <= (gnd_lim_q < adv_lim) ? gnd_lim_q[15:0]
                                                                : adv_lim[15:0]; // [RULE12]
                    limit_valid_out <= 1'b1;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### hw/scap_defs.vh
// Purpose: Constants for the source current advertisement policy block
// Assumes: 40 MHz system clock
// Notes: Currents in mA, impedances in milliohm
`ifndef SCAP_DEFS_VH
`define SCAP_DEFS_VH
`define SCAP_ADV_DEFAULT 2'h0
`define SCAP_ADV_1A5 2'h1
`define SCAP_ADV_3A0 2'h2
`define SCAP_RATE_1A5_MA 16'h05dc
`define SCAP_RATE_3A0_MA 16'h0bb8
`define SCAP_CABLE_5A_MA 16'h1388
`define SCAP_CLK_MHZ 40
`define SCAP_VBUSON_US 275
`define SCAP_VBUSON_CYC ((`SCAP_VBUSON_US * `SCAP_CLK_MHZ) - 1)
`define SCAP_STABLE_US 10
`define SCAP_STABLE_CYC ((`SCAP_STABLE_US * `SCAP_CLK_MHZ))
`define SCAP_GND_MV 250
`define SCAP_SUP_MV 750
`define SCAP_SUP_STEP_MOHM 2
`endif

// ### hw/scap_sync.v
// Purpose: Two-stage synchroniser for a bus of pin inputs
// Assumes: Inputs asynchronous to sys_clk_in
// Notes: First stage feeds only the second stage
`default_nettype none
module scap_sync #(
    parameter W = 1
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            meta_q <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### hw/scap_div.v
// Purpose: Sequential unsigned divider, one quotient bit per clock
// Assumes: Start only when idle
// Notes: Quotient saturates when divisor is zero
`default_nettype none
module scap_div #(
    parameter W = 32
) (
    input wire sys_clk_in,
    input wire rst_in,
    input wire start_in,
    input wire [W-1:0] num_in,
    input wire [W-1:0] den_in,
    output reg [W-1:0] quo_out,
    output reg done_out
);
    reg [W-1:0] n_q;
    reg [W-1:0] d_q;
    reg [W:0] rem_q;
    reg [6:0] cnt_q;
    reg busy_q;
    localparam [6:0] STEPS = W;
    wire [W:0] trial = {rem_q[W-1:0], n_q[W-1]};
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            n_q <= {W{1'b0}};
            d_q <= {W{1'b0}};
            rem_q <= {(W+1){1'b0}};
            cnt_q <= 7'h00;
            busy_q <= 1'b0;
            quo_out <= {W{1'b0}};
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_q) begin
                n_q <= num_in;
                d_q <= den_in;
                rem_q <= {(W+1){1'b0}};
                cnt_q <= STEPS;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (trial >= {1'b0, d_q}) begin
                    rem_q <= trial - {1'b0, d_q};
                    n_q <= {n_q[W-2:0], 1'b1};
                end else begin
                    rem_q <= trial;
                    n_q <= {n_q[W-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 7'h01;
                if (cnt_q == 7'h01) begin
                    busy_q <= 1'b0;
                    done_out <= 1'b1;
                    quo_out <= (trial >= {1'b0, d_q}) ? {n_q[W-2:0], 1'b1}
                                                      : {n_q[W-2:0], 1'b0};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/scap_policy_properties.sv
// Purpose: Port checks for the advertisement policy
// Assumes: One clock, synchronous active-high reset
// Notes: Pin events land late through the synchronisers
`default_nettype none
module scap_policy_properties #(
    parameter int STABLE_CYC = 400,
    parameter int PD_REV3 = 0,
    parameter int SUSPEND_DEFAULT = 1
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic attach_in,
    input wire logic suspend_in,
    input wire logic rail_good_in,
    input wire logic contract_in,
    input wire logic ps_rdy_ack_in,
    input wire logic raise_in,
    input wire logic [1:0] ca_adv_in,
    input wire logic adapter_present_in,
    input wire logic [1:0] current_advert_pullup_out,
    input wire logic advert_valid_out,
    input wire logic pd_msg_enable_out,
    input wire logic [15:0] host_limit_ma_out,
    input wire logic limit_valid_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic att_q, sus_q, con_q, ack_q;
    logic [7:0] hist_q;
    logic [15:0] good_q;
    wire evt = (attach_in != att_q) | (suspend_in != sus_q) | (contract_in != con_q)
        | ps_rdy_ack_in | raise_in;
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            {att_q, sus_q, con_q, ack_q} <= 4'h0;
            hist_q <= 8'h00;
            good_q <= 16'h0000;
        end else begin
            {att_q, sus_q, con_q} <= {attach_in, suspend_in, contract_in};
            hist_q <= {hist_q[6:0], evt};
            ack_q <= contract_in & (ack_q | ps_rdy_ack_in);
            // Raw count; the design also loses cycles in its synchroniser
            if (!(rail_good_in && attach_in)) good_q <= 16'h0000;
            else if (good_q != 16'hffff) good_q <= good_q + 16'h0001;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    a_reset_quiet: assert property (
        $past(rst_in) |-> current_advert_pullup_out == 2'h0 && !advert_valid_out
            && !pd_msg_enable_out && !limit_valid_out) else $error("reset not quiet");
    a_advert_event: assert property (
        $changed(current_advert_pullup_out) |-> |{hist_q, evt}) else $error("advert moved");
    a_attach_deadline: assert property (
        $rose(attach_in) |-> ##[1:5] advert_valid_out) else $error("advert late");
    a_suspend_default: assert property (
        SUSPEND_DEFAULT != 0 && !contract_in && $rose(suspend_in)
            |-> ##[1:5] current_advert_pullup_out == 2'h0) else $error("suspend advert");
    a_pd_rail_stable: assert property (
        $rose(pd_msg_enable_out) |-> good_q >= STABLE_CYC) else $error("messaging early");
    a_rev2_levels: assert property (
        PD_REV3 == 0 && contract_in && $past(ack_q)
            |-> current_advert_pullup_out inside {2'h1, 2'h2}) else $error("rev2 level");
    a_rev3_entry: assert property (
        PD_REV3 != 0 && $rose(contract_in)
            |-> ##[1:2] current_advert_pullup_out == ca_adv_in) else $error("rev3 entry");
    a_limit_capped: assert property (
        limit_valid_out && adapter_present_in && current_advert_pullup_out == 2'h2
            |-> host_limit_ma_out <= 16'h0bb8) else $error("limit above advert");
    cover property ($rose(pd_msg_enable_out));
    cover property (limit_valid_out && adapter_present_in);
    cover property (contract_in && ps_rdy_ack_in);
endmodule
bind scap_policy scap_policy_properties #(.STABLE_CYC(STABLE_CYC), .PD_REV3(PD_REV3),
    .SUSPEND_DEFAULT(SUSPEND_DEFAULT)) scap_policy_properties_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .attach_in(attach_in),
    .suspend_in(suspend_in), .rail_good_in(rail_good_in), .contract_in(contract_in),
    .ps_rdy_ack_in(ps_rdy_ack_in), .raise_in(raise_in), .ca_adv_in(ca_adv_in),
    .adapter_present_in(adapter_present_in),
    .current_advert_pullup_out(current_advert_pullup_out),
    .advert_valid_out(advert_valid_out), .pd_msg_enable_out(pd_msg_enable_out),
    .host_limit_ma_out(host_limit_ma_out), .limit_valid_out(limit_valid_out));
`default_nettype wire

// ### sim/scap_sink_model.sv
// Purpose: Pass-through adapter model reporting its path impedance
// Assumes: Profile zero means no adapter
// Notes: Released fields toggle so stale values are never trusted
`default_nettype none
module scap_sink_model (
    input wire logic sys_clk_in,
    input wire logic [1:0] profile_in,
    output logic adapter_present_out,
    output logic [15:0] gnd_mohm_out,
    output logic [15:0] sup_2mohm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {adapter_present_out, gnd_mohm_out, sup_2mohm_out} = 33'h0;
    // Worst-case figures, connector pair and switches included
    always @(posedge sys_clk_in) begin
        adapter_present_out <= (profile_in != 2'h0);
        case (profile_in)
            2'h1: {gnd_mohm_out, sup_2mohm_out} <= {16'h000a, 16'h000a};
            2'h2: {gnd_mohm_out, sup_2mohm_out} <= {16'h0028, 16'h0028};
            2'h3: {gnd_mohm_out, sup_2mohm_out} <= {16'h000a, 16'h0028};
            default: {gnd_mohm_out, sup_2mohm_out} <= ~{gnd_mohm_out, sup_2mohm_out};
        endcase
    end
endmodule
`default_nettype wire

// ### sim/scap_policy_tb_top.sv
// Purpose: Self-checking bench for the advertisement policy
// Assumes: Six policy variants share one set of inputs
// Notes: Advert code 3 in a row means not checked
`default_nettype none
`define SCAP_CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    n_mismatch++; $display("ERROR %s expected %0d seen %0d", nm, ex, got); end end
module scap_policy_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STB = 8;
    localparam logic [15:0] RATE [6] = '{16'h0bb8, 16'h0bb7, 16'h05dc, 16'h05db,
        16'h0bb8, 16'h0bb8};
    localparam bit SHR [6] = '{0, 0, 0, 0, 1, 0};
    localparam bit REV [6] = '{0, 0, 0, 0, 0, 1};
    typedef struct packed {logic at, su, co, ak, ra; logic [1:0] ca; logic [11:0] ex;} scap_row_t;
    localparam scap_row_t ROWS [8] = '{
        '{1, 0, 0, 0, 0, 2'h0, {2'h2, 2'h1, 2'h0, 2'h1, 2'h1, 2'h2}},
        '{1, 1, 0, 0, 0, 2'h0, 12'h000},
        '{1, 0, 0, 0, 0, 2'h0, {2'h2, 2'h3, 2'h0, 2'h1, 2'h1, 2'h2}},
        '{1, 0, 0, 0, 1, 2'h0, {2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2}},
        '{1, 0, 1, 0, 0, 2'h1, {2'h1, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2}},
        '{1, 0, 1, 0, 0, 2'h2, {2'h1, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2}},
        '{1, 0, 1, 1, 0, 2'h2, {2'h3, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2}},
        '{1, 0, 0, 0, 0, 2'h0, {2'h2, 2'h3, 2'h0, 2'h1, 2'h1, 2'h2}}};
    // Adapter profile, offered current, lower-detach choice
    localparam logic [18:0] LROW [7] = '{{2'h1, 16'h0bb8, 1'h0}, {2'h1, 16'h1388, 1'h0},
        {2'h2, 16'h1388, 1'h0}, {2'h2, 16'h0bb8, 1'h0}, {2'h3, 16'h0bb8, 1'h0},
        {2'h3, 16'h0bb8, 1'h1}, {2'h2, 16'h0bb9, 1'h1}};
    logic clk = 0, rst = 1, at = 0, su = 0, rg = 0, co = 0, ak = 0, ra = 0, ld = 0, cd = 0;
    logic [1:0] ca = 2'h0, prof = 2'h0;
    logic [15:0] pdo = 16'h0bb8, cc = 16'h1388;
    logic ap;
    logic [15:0] gnd, sup;
    logic [1:0] adv [6];
    logic vld [6], pde [6], pdx [6], ofr [6], lv [6];
    logic [15:0] lim [6];
    integer n_mismatch = 0, samples_checked = 0;
    int e;
    always #12.5 clk = ~clk;
    scap_sink_model scap_sink_model_inst (.sys_clk_in(clk), .profile_in(prof),
        .adapter_present_out(ap), .gnd_mohm_out(gnd), .sup_2mohm_out(sup));
    for (genvar i = 0; i < 6; i++) begin : g_dut
        scap_policy #(.RATING_MA(RATE[i]), .SHARED_CAP(SHR[i]), .PD_REV3(REV[i]),
            .VBUSON_CYC(20), .STABLE_CYC(STB)) scap_policy_inst (
            .sys_clk_in(clk), .rst_in(rst), .attach_in(at), .suspend_in(su),
            .rail_good_in(rg), .contract_in(co), .ps_rdy_ack_in(ak), .raise_in(ra),
            .ca_adv_in(ca), .src_max_pdo_ma_in(pdo), .adapter_present_in(ap),
            .adapter_ground_resistance_in(gnd), .adapter_supply_resistance_in(sup),
            .lower_detach_in(ld), .cable_disc_done_in(cd), .cable_cap_ma_in(cc),
            .current_advert_pullup_out(adv[i]), .advert_valid_out(vld[i]),
            .pd_msg_enable_out(pde[i]), .pd_only_out(pdx[i]),
            .offer_above_3a_out(ofr[i]), .host_limit_ma_out(lim[i]), .limit_valid_out(lv[i]));
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk_adv(input logic [11:0] ex);
        for (int i = 0; i < 6; i++)
            if (ex[2*i+:2] !== 2'h3) `SCAP_CHK("advert", ex[2*i+:2], adv[i])
    endtask
    // Pulse per pass; the first may predate the new inputs
    task automatic wait_lv;
        int k;
        k = 0;
        while (lv[0] !== 1'b1 && k < 300) begin cyc(1); k++; end
        if (k == 300) n_mismatch++;
        cyc(1);
    endtask
    function automatic int exp_lim(input int ic, input int g_m, input int s_u, input bit low);
        int g, s, m;
        g = 250000000 / (250000000 / ic + g_m * 1000);
        s = 750000000 / (750000000 / ic + (2 * s_u + g_m) * 1000);
        m = (low || g < s) ? g : s;
        return (m < 3000) ? m : 3000;
    endfunction
    initial begin
        #(25 * 6000);
        n_mismatch++;
        summarize();
    end
    initial begin
        cyc(10);
        rst = 0;
        foreach (ROWS[r]) begin
            {at, su, co, ak, ra, ca} = ROWS[r][18:12];
            cyc(1);
            {ak, ra} = 2'h0;
            cyc(6);
            chk_adv(ROWS[r].ex);
        end
        `SCAP_CHK("valid", 1'b1, vld[0])
        `SCAP_CHK("pd_only", 1'b0, pdx[0])
        `SCAP_CHK("pd_early", 1'b0, pde[0])
        rg = 1;
        cyc(STB);
        `SCAP_CHK("pd_early", 1'b0, pde[0])
        cyc(8);
        `SCAP_CHK("pd_on", 1'b1, pde[0])
        cd = 1;
        foreach (LROW[r]) begin
            {prof, pdo, ld} = LROW[r];
            cyc(2);
            wait_lv();
            wait_lv();
            e = exp_lim((pdo > 16'h0bb8) ? 5000 : 3000, gnd, sup, ld);
            `SCAP_CHK("limit", 1'b1, lim[0] + 16'h2 >= e[15:0] && lim[0] <= e[15:0] + 16'h2)
            `SCAP_CHK("offer", 1'b0, ofr[0])
        end
        rst = 1;
        cyc(2);
        `SCAP_CHK("rst_adv", 2'h0, adv[0])
        `SCAP_CHK("rst_vld", 1'b0, vld[0])
        rst = 0;
        cyc(7);
        chk_adv({2'h2, 2'h1, 2'h0, 2'h1, 2'h1, 2'h2});
        summarize();
    end
endmodule
`undef SCAP_CHK
`default_nettype wire
